/* File: logic/ums_pkg.sv */
// Shared constants and types for the modem control and line status block
package ums_pkg;
  // Register byte offsets (one aligned word each)
  localparam logic [7:0] UMS_OFS_CTRL  = 8'h10;
  localparam logic [7:0] UMS_OFS_LINE  = 8'h14;
  localparam logic [7:0] UMS_OFS_MSTAT = 8'h18;
  localparam int         UMS_DEC_LO    = 2;
  localparam int         UMS_DEC_HI    = 7;

  // Modem control register fields: handshake outputs, loopback and second DMA mode
  localparam int UMS_CTL_DTR  = 0;
  localparam int UMS_CTL_RTS  = 1;
  localparam int UMS_CTL_USER_OUTPUT_ONE_BIT = 2;
  localparam int UMS_CTL_USER_OUTPUT_TWO_BIT = 3;
  localparam int UMS_CTL_LOOP = 4;
  localparam int UMS_CTL_DMA2 = 5;
  localparam int UMS_CTL_USER_OUTPUT_THREE_BIT = 6;
  localparam logic [7:0] UMS_CTL_RST  = 8'h00;
  localparam logic [7:0] UMS_CTL_MASK = 8'h7F;

  // Line state flag fields
  localparam int UMS_LSR_DR   = 0;
  localparam int UMS_LSR_OE   = 1;
  localparam int UMS_LSR_ERRS = 2;
  localparam int UMS_LSR_THRE = 5;
  localparam int UMS_LSR_TEMT = 6;
  localparam int UMS_LSR_FERR = 7;

  // Per-character error flags as queued: {break, framing, parity}
  localparam int UMS_ERR_W  = 3;
  localparam int UMS_ERR_PE = 0;
  localparam int UMS_ERR_FE = 1;
  localparam int UMS_ERR_BI = 2;

  // Error injection test fields
  localparam int UMS_TST_W    = 5;
  localparam int UMS_TST_PAR  = 0;
  localparam int UMS_TST_FRM  = 1;
  localparam int UMS_TST_BAUD = 2;
  localparam int UMS_TST_PHY  = 3;
  localparam int UMS_TST_CRC  = 4;
  localparam logic [4:0] UMS_TST_RST = 5'h00;

  // Modem line index, shared by pins, levels and deltas
  localparam int UMS_M_CTS = 0;
  localparam int UMS_M_DSR = 1;
  localparam int UMS_M_RI  = 2;
  localparam int UMS_M_DCD = 3;
  localparam logic [3:0] UMS_LINE_IDLE = 4'hF;

  // AHB-Lite transfer type bit meaning a real transfer
  localparam int UMS_HTRANS_ACT = 1;

  // Bus data phase state
  typedef enum logic [0:0] {
    UMS_BUS_IDLE  = 1'b0,
    UMS_BUS_WDATA = 1'b1
  } ums_bus_t;
endpackage

/* File: logic/ums_modem_if.sv */
// Carrier between the line status core and the modem input watcher
`timescale 1ns/10ps
interface ums_modem_if;
  logic [3:0] line_n;
  logic       rd_clr;
  logic [3:0] level;
  logic [3:0] delta;
  modport watch (input line_n, input rd_clr, output level, output delta);
  modport core  (output line_n, output rd_clr, input level, input delta);
endinterface

/* File: logic/ums_modem_watch.sv */
// Modem input level and change-flag tracker
`timescale 1ns/10ps
module ums_modem_watch (
  // Clock and reset
  input  wire logic  i_clk,
  input  wire logic  i_rst_n,
  // Core side
  ums_modem_if.watch mif
);
  import ums_pkg::*;

  logic [3:0] prev_n;
  logic [3:0] level;
  logic [3:0] delta;
  logic [3:0] next_prev_n;
  logic [3:0] next_level;
  logic [3:0] next_delta;
  logic [3:0] change;

  // Change events; ring only on its trailing edge, low to high on the pin
  always_comb begin
    change             = prev_n ^ mif.line_n;
    change[UMS_M_RI]   = ~prev_n[UMS_M_RI] & mif.line_n[UMS_M_RI];
    next_prev_n        = mif.line_n;
    next_level         = ~mif.line_n;
    // Event beats a read clear in the same cycle
    next_delta         = change | (delta & ~{4{mif.rd_clr}});
  end

  // Idle pins are high, so reset assumes no pending change
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_n <= UMS_LINE_IDLE;
      level  <= 4'h0;
      delta  <= 4'h0;
    end else begin
      prev_n <= next_prev_n;
      level  <= next_level;
      delta  <= next_delta;
    end
  end

  assign mif.level = level;
  assign mif.delta = delta;

  property p_delta_kept;
    @(posedge i_clk) disable iff (!i_rst_n)
    (mif.line_n[UMS_M_DCD] != prev_n[UMS_M_DCD]) && mif.rd_clr |=> delta[UMS_M_DCD];
  endproperty
  a_delta_kept: assert property (p_delta_kept) else $error("dcd delta lost on read");

  property p_ring_lead_ignored;
    @(posedge i_clk) disable iff (!i_rst_n)
    prev_n[UMS_M_RI] && !mif.line_n[UMS_M_RI] && mif.rd_clr |=> !delta[UMS_M_RI];
  endproperty
  a_ring_lead_ignored: assert property (p_ring_lead_ignored) else $error("ring fall flagged");

  property p_level_inverted;
    @(posedge i_clk) disable iff (!i_rst_n)
    1'b1 |=> level == ~$past(mif.line_n);
  endproperty
  a_level_inverted: assert property (p_level_inverted) else $error("modem level not inverted");
endmodule // ums_modem_watch

/* File: logic/ums_line_status.sv */
// Modem control, line status, test injection and modem status block
// Functional notes
// - Control bit 0 set drives terminal-ready pin low; clear drives it high.
// - Bits 1,2,3,6 drive send-request and user pins one-three, active low.
// - Control bit 4 enables loopback; bit 7 reserved.
// - Control bit 5 selects second DMA signalling for ready outputs, except in fast infrared mode.
// - Loopback feeds transmit stream to receiver; input ignored, output held 1.
// - Loopback: modem inputs follow send-request, terminal-ready, user one, user two.
// - Loopback ignores modem input pins and forces all five output pins high.
// - Bit 7 zero without FIFOs; set by flagged character; clears on status read when none remain.
// - Bit 6 one when holding and shift register empty; clears on new write.
// - Bit 5 follows holding byte empty, or FIFO fully empty; requests interrupt.
// - Break sets bit 4 with framing error, one zero character; cleared on read.
// - Bit 3 flags zero stop bit, queued per character, cleared on read.
// - Bit 2 flags parity; buffer read loads new top flags; cleared on read.
// - Overrun without FIFOs sets bit 1, keeps held character, drops new one.
// - Overrun with FIFOs sets bit 1 at once, not queued, cleared on read.
// - Bit 0 one while unread characters wait; clears when all read.
// - Test register shares line status offset; bits 4,3 corrupt fast infrared CRC, chips.
// - Test bit 1 zero stop, bit 0 wrong parity, bit 2 faster divider toggle.
// - Loopback only in serial and slow infrared modes, never fast infrared.
// - Modem status bits 7..4 read inverted carrier, ring, set-ready, clear-to-send.
// - Bits 3,1,0 flag changes; bit 2 flags ring low-to-high.
// - Low four status bits clear on read; any set requests modem interrupt.
// - Control register read/write at byte offset 0x10.
`timescale 1ns/10ps
module ums_line_status #(
  parameter int RX_DEPTH = 16
) (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rstn,
  // AHB-Lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hwdata,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // Serial and modem pins
  input  wire logic        i_serial_in,
  input  wire logic        i_clear_to_send_n,
  input  wire logic        i_set_ready_n,
  input  wire logic        i_ring_n,
  input  wire logic        i_carrier_detect_n,
  output logic             o_serial_out,
  output logic             o_terminal_ready_n,
  output logic             o_send_request_n,
  output logic             o_user_pin_one_n,
  output logic             o_user_pin_two_n,
  output logic             o_user_pin_three_n,
  // Transmitter and receiver core
  input  wire logic        i_fifo_en,
  input  wire logic        i_fast_infrared_mode,
  input  wire logic        i_tx_serial,
  input  wire logic        i_thr_write,
  input  wire logic        i_thr_empty,
  input  wire logic        i_txf_empty,
  input  wire logic        i_tsr_empty,
  input  wire logic        i_rx_done,
  input  wire logic        i_rx_perr,
  input  wire logic        i_rx_ferr,
  input  wire logic        i_rx_brk,
  input  wire logic        i_rbr_read,
  input  wire logic        i_rx_flush,
  input  wire logic        i_rx_trigger_hit,
  input  wire logic        i_txf_trigger_hit,
  output logic             o_rx_serial,
  output logic             o_rx_store,
  output logic             o_loopback,
  // Test injection and requests
  output logic             o_inject_wrong_parity,
  output logic             o_inject_zero_stop,
  output logic             o_fast_divider_toggle,
  output logic             o_inject_bad_pulse_chips,
  output logic             o_inject_bad_crc,
  output logic             o_rx_dma_ready_n,
  output logic             o_tx_dma_ready_n,
  output logic             o_modem_status_req,
  output logic             o_thr_empty_req
);
  import ums_pkg::*;

  localparam int PW = $clog2(RX_DEPTH);
  localparam int CW = $clog2(RX_DEPTH + 1);

  // Word-address match on the low byte of the address
  function automatic logic reg_hit(input logic [31:0] addr, input logic [7:0] ofs);
    reg_hit = (addr[UMS_DEC_HI:UMS_DEC_LO] == ofs[UMS_DEC_HI:UMS_DEC_LO]);
  endfunction

  // Reset release through two flops
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // Pin synchronisers: first stage feeds only the second
  logic [4:0] pin_s1;
  logic [4:0] pin_s2;
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 5'h1F;
      pin_s2 <= 5'h1F;
    end else begin
      pin_s1 <= {i_serial_in, i_carrier_detect_n, i_ring_n, i_set_ready_n, i_clear_to_send_n};
      pin_s2 <= pin_s1;
    end
  end

  // Registers and next values
  ums_bus_t    bus_st;
  ums_bus_t    next_bus_st;
  logic [31:0] wr_addr;
  logic [31:0] next_wr_addr;
  logic [31:0] next_hrdata;
  logic [7:0]  ctrl;
  logic [7:0]  next_ctrl;
  logic [4:0]  tst;
  logic [4:0]  next_tst;
  logic        rd_line;
  logic        rd_mstat;
  logic        addr_ok;
  logic        loop_eff;
  logic [7:0]  line_word;

  ums_modem_if mif ();

  // Loopback never applies in fast infrared mode
  assign loop_eff = ctrl[UMS_CTL_LOOP] & ~i_fast_infrared_mode;

  // Internal modem inputs: pins, or control bits as the far pins would show them
  always_comb begin
    if (loop_eff) begin
      mif.line_n[UMS_M_CTS] = ~ctrl[UMS_CTL_RTS];
      mif.line_n[UMS_M_DSR] = ~ctrl[UMS_CTL_DTR];
      mif.line_n[UMS_M_RI]  = ~ctrl[UMS_CTL_USER_OUTPUT_ONE_BIT];
      mif.line_n[UMS_M_DCD] = ~ctrl[UMS_CTL_USER_OUTPUT_TWO_BIT];
    end else begin
      mif.line_n = pin_s2[3:0];
    end
  end

  ums_modem_watch u_watch (
    .i_clk   (i_ref_clk),
    .i_rst_n (rst_n),
    .mif     (mif.watch)
  );

  // Receive error flag queue, one entry per character held
  logic [UMS_ERR_W-1:0] flag_mem [RX_DEPTH];
  logic [PW-1:0]        wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [CW-1:0]        count, next_count, err_cnt, next_err_cnt;
  logic [UMS_ERR_W-1:0] top_err, next_top_err, in_err, after_err;
  logic                 ovr, next_ovr, ferr_sum, next_ferr_sum;
  logic                 full, push, pop, in_bad, out_bad;
  logic                 store, next_store;

  // Queue bookkeeping and sticky error flags
  always_comb begin
    // Break always brings a framing error along
    in_err               = '0;
    in_err[UMS_ERR_PE]   = i_rx_perr;
    in_err[UMS_ERR_FE]   = i_rx_ferr | i_rx_brk;
    in_err[UMS_ERR_BI]   = i_rx_brk;
    in_bad               = |in_err;
    full                 = i_fifo_en ? (count == CW'(RX_DEPTH)) : (count != '0);
    push                 = i_rx_done & ~full & ~i_rx_flush;
    pop                  = i_rbr_read & (count != '0) & ~i_rx_flush;
    out_bad              = |flag_mem[rd_ptr];
    after_err            = (count > CW'(1)) ? flag_mem[PW'(rd_ptr + 1'b1)]
                                            : (push ? in_err : '0);
    next_store           = push;
    next_wr_ptr          = push ? PW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr          = pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
    next_count           = CW'(count + CW'(push) - CW'(pop));
    next_err_cnt         = CW'(err_cnt + CW'(push & in_bad) - CW'(pop & out_bad));
    // New top-of-queue flags win over a status read clear
    next_top_err         = top_err & ~{UMS_ERR_W{rd_line}};
    if (pop) begin
      next_top_err       = after_err;
    end else if (push && count == '0) begin
      next_top_err       = in_err;
    end
    // Overrun is flagged at once and never queued
    next_ovr             = (i_rx_done & full) | (ovr & ~rd_line);
    next_ferr_sum        = i_fifo_en & ((push & in_bad)
                           | (ferr_sum & ~(rd_line & next_err_cnt == '0)));
    if (i_rx_flush) begin
      next_wr_ptr        = '0;
      next_rd_ptr        = '0;
      next_count         = '0;
      next_err_cnt       = '0;
      next_top_err       = '0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
      err_cnt  <= '0;
      top_err  <= '0;
      ovr      <= 1'b0;
      ferr_sum <= 1'b0;
      store    <= 1'b0;
    end else begin
      wr_ptr   <= next_wr_ptr;
      rd_ptr   <= next_rd_ptr;
      count    <= next_count;
      err_cnt  <= next_err_cnt;
      top_err  <= next_top_err;
      ovr      <= next_ovr;
      ferr_sum <= next_ferr_sum;
      store    <= next_store;
    end
  end

  // Flag storage has no reset; entries are only read once written
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      flag_mem[wr_ptr] <= in_err;
    end
  end

  // Live line state word as software reads it
  logic thre, temt;
  always_comb begin
    thre                   = i_fifo_en ? i_txf_empty : i_thr_empty;
    temt                   = thre & i_tsr_empty & ~i_thr_write;
    line_word              = 8'h00;
    line_word[UMS_LSR_DR]  = (count != '0);
    line_word[UMS_LSR_OE]  = ovr;
    line_word[UMS_LSR_ERRS +: UMS_ERR_W] = top_err;
    line_word[UMS_LSR_THRE] = thre;
    line_word[UMS_LSR_TEMT] = temt;
    line_word[UMS_LSR_FERR] = ferr_sum & i_fifo_en;
  end

  // AHB-Lite slave: zero wait, reads answered from a flop in the data phase
  always_comb begin
    addr_ok      = i_hsel & i_hready & i_htrans[UMS_HTRANS_ACT];
    rd_line      = addr_ok & ~i_hwrite & reg_hit(i_haddr, UMS_OFS_LINE);
    rd_mstat     = addr_ok & ~i_hwrite & reg_hit(i_haddr, UMS_OFS_MSTAT);
    mif.rd_clr   = rd_mstat;
    next_bus_st  = (addr_ok & i_hwrite) ? UMS_BUS_WDATA : UMS_BUS_IDLE;
    next_wr_addr = (addr_ok & i_hwrite) ? i_haddr : wr_addr;
    next_hrdata  = 32'h0000_0000;
    if (addr_ok && !i_hwrite) begin
      if (reg_hit(i_haddr, UMS_OFS_CTRL)) begin
        next_hrdata[7:0] = ctrl;
      end else if (rd_line) begin
        next_hrdata[7:0] = line_word;
      end else if (rd_mstat) begin
        next_hrdata[7:0] = {mif.level, mif.delta};
      end
    end
    next_ctrl = ctrl;
    next_tst  = tst;
    if (bus_st == UMS_BUS_WDATA) begin
      if (reg_hit(wr_addr, UMS_OFS_CTRL)) begin
        next_ctrl = i_hwdata[7:0] & UMS_CTL_MASK;
      end else if (reg_hit(wr_addr, UMS_OFS_LINE)) begin
        next_tst  = i_hwdata[UMS_TST_W-1:0];
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_st      <= UMS_BUS_IDLE;
      wr_addr     <= 32'h0000_0000;
      o_hrdata    <= 32'h0000_0000;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      ctrl        <= UMS_CTL_RST;
      tst         <= UMS_TST_RST;
    end else begin
      bus_st      <= next_bus_st;
      wr_addr     <= next_wr_addr;
      o_hrdata    <= next_hrdata;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      ctrl        <= next_ctrl;
      tst         <= next_tst;
    end
  end

  // Output stage; every port leaves from a flop, costing one cycle of delay
  logic [22:0] next_outs;
  logic        dma2;
  always_comb begin
    dma2          = ctrl[UMS_CTL_DMA2] & ~i_fast_infrared_mode;
    next_outs[0]  = loop_eff | i_tx_serial;
    next_outs[1]  = loop_eff | ~ctrl[UMS_CTL_DTR];
    next_outs[2]  = loop_eff | ~ctrl[UMS_CTL_RTS];
    next_outs[3]  = loop_eff | ~ctrl[UMS_CTL_USER_OUTPUT_ONE_BIT];
    next_outs[4]  = loop_eff | ~ctrl[UMS_CTL_USER_OUTPUT_TWO_BIT];
    next_outs[5]  = loop_eff | ~ctrl[UMS_CTL_USER_OUTPUT_THREE_BIT];
    next_outs[6]  = loop_eff ? i_tx_serial : pin_s2[4];
    next_outs[7]  = loop_eff;
    // Fast infrared faults only matter in that mode, serial faults outside it
    next_outs[8]  = tst[UMS_TST_PAR] & ~i_fast_infrared_mode;
    next_outs[9]  = tst[UMS_TST_FRM] & ~i_fast_infrared_mode;
    next_outs[10] = tst[UMS_TST_BAUD];
    next_outs[11] = tst[UMS_TST_PHY] & i_fast_infrared_mode;
    next_outs[12] = tst[UMS_TST_CRC] & i_fast_infrared_mode;
    // Mode 0 signals single characters, mode 2 the trigger levels
    next_outs[13] = dma2 ? ~(i_fifo_en & i_rx_trigger_hit) : (count == '0);
    next_outs[14] = dma2 ? ~(i_fifo_en & i_txf_trigger_hit) : ~thre;
    next_outs[15] = |mif.delta;
    next_outs[16] = thre;
    next_outs[22:17] = '0;
  end

  logic [22:0] outs;
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      outs <= 23'h00_007F;
    end else begin
      outs <= next_outs;
    end
  end

  assign o_serial_out             = outs[0];
  assign o_terminal_ready_n       = outs[1];
  assign o_send_request_n         = outs[2];
  assign o_user_pin_one_n         = outs[3];
  assign o_user_pin_two_n         = outs[4];
  assign o_user_pin_three_n       = outs[5];
  assign o_rx_serial              = outs[6];
  assign o_loopback               = outs[7];
  assign o_inject_wrong_parity    = outs[8];
  assign o_inject_zero_stop       = outs[9];
  assign o_fast_divider_toggle    = outs[10];
  assign o_inject_bad_pulse_chips = outs[11];
  assign o_inject_bad_crc         = outs[12];
  assign o_rx_dma_ready_n         = outs[13];
  assign o_tx_dma_ready_n         = outs[14];
  assign o_modem_status_req       = outs[15];
  assign o_thr_empty_req          = outs[16];
  assign o_rx_store               = store;

  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_tst_write;
    addr_ok && i_hwrite && reg_hit(i_haddr, UMS_OFS_LINE) ##1 i_hwdata[UMS_TST_FRM];
  endsequence

  property p_dtr_pin;
    !loop_eff && ctrl[UMS_CTL_DTR] |=> !o_terminal_ready_n;
  endproperty
  a_dtr_pin: assert property (p_dtr_pin) else $error("terminal ready not low");

  property p_user_three;
    !loop_eff |=> o_user_pin_three_n == !$past(ctrl[UMS_CTL_USER_OUTPUT_THREE_BIT]);
  endproperty
  a_user_three: assert property (p_user_three) else $error("user pin three wrong");

  property p_loop_pins;
    loop_eff |=> o_terminal_ready_n && o_send_request_n && o_user_pin_one_n
                 && o_user_pin_two_n && o_user_pin_three_n && o_serial_out;
  endproperty
  a_loop_pins: assert property (p_loop_pins) else $error("pins not idle in loopback");

  property p_loop_rx;
    loop_eff |=> o_rx_serial == $past(i_tx_serial);
  endproperty
  a_loop_rx: assert property (p_loop_rx) else $error("loopback stream broken");

  property p_overrun;
    i_rx_done && full |=> ovr && !store;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_ready_read;
    rd_line |=> o_hrdata[UMS_LSR_DR] == ($past(count) != '0);
  endproperty
  a_ready_read: assert property (p_ready_read) else $error("data ready wrong");

  property p_fifo_off_err;
    rd_line && !i_fifo_en |=> !o_hrdata[UMS_LSR_FERR];
  endproperty
  a_fifo_off_err: assert property (p_fifo_off_err) else $error("bit 7 set without FIFOs");

  property p_temt_write;
    rd_line && i_thr_write |=> !o_hrdata[UMS_LSR_TEMT];
  endproperty
  a_temt_write: assert property (p_temt_write) else $error("empty shown during write");

  property p_zero_stop;
    s_tst_write ##0 !i_fast_infrared_mode ##1 !i_fast_infrared_mode |=> o_inject_zero_stop;
  endproperty
  a_zero_stop: assert property (p_zero_stop) else $error("zero stop not injected");
endmodule // ums_line_status

/* File: test/ums_modem_model.sv */
// Far-side modem equipment driving handshake lines and toggling serial data
`timescale 1ns/10ps
module ums_modem_model (
  // Clock and request from the bench
  input  wire logic       i_clk,
  input  wire logic [3:0] i_want_n,
  // Pins toward the block
  output logic      [3:0] o_line_n = 4'hF,
  output logic            o_sdata  = 1'b1
);
  // Lines move only just after an edge, like real equipment on a clocked bench
  always @(posedge i_clk) begin
    o_line_n <= i_want_n;
    o_sdata  <= ~o_sdata; // Toggling data so a leak past loopback is visible
  end
endmodule // ums_modem_model

/* File: test/testbench.sv */
// Self-checking bench for the modem control and line status block
`timescale 1ns/10ps
module testbench;
  import ums_pkg::*;
  logic i_ref_clk = 0, i_rstn = 0, i_hsel = 0, i_hwrite = 0, i_serial_in;
  logic [31:0] i_haddr = 0, i_hwdata = 0, o_hrdata, q;
  logic [1:0] i_htrans = 0;
  logic [3:0] want_n = 4'hF, ln, old_n;
  logic i_fifo_en = 1, i_fast_infrared_mode = 0, i_tx_serial = 0, i_thr_write = 0;
  logic i_thr_empty = 1, i_txf_empty = 1, i_tsr_empty = 1, i_rx_done = 0, i_rx_perr = 0;
  logic i_rx_ferr = 0, i_rx_brk = 0, i_rbr_read = 0, i_rx_flush = 0;
  logic i_rx_trigger_hit = 0, i_txf_trigger_hit = 0, o_hreadyout, o_hresp, o_serial_out;
  logic i_clear_to_send_n, i_set_ready_n, i_ring_n, i_carrier_detect_n;
  logic o_terminal_ready_n, o_send_request_n, o_user_pin_one_n, o_user_pin_two_n;
  logic o_user_pin_three_n, o_rx_serial, o_rx_store, o_loopback, o_inject_wrong_parity;
  logic o_inject_zero_stop, o_fast_divider_toggle, o_inject_bad_pulse_chips, o_inject_bad_crc;
  logic o_rx_dma_ready_n, o_tx_dma_ready_n, o_modem_status_req, o_thr_empty_req;
  logic [2:0] i_hsize = 3'h2;
  logic [7:0] v;
  int err_total = 0, compares = 0, cyc = 0;
  assign {i_carrier_detect_n, i_ring_n, i_set_ready_n, i_clear_to_send_n} = ln;
  ums_line_status #(.RX_DEPTH(4)) dut (.i_hready(o_hreadyout), .*);
  ums_modem_model peer (.i_clk(i_ref_clk), .i_want_n(want_n), .o_line_n(ln),
                        .o_sdata(i_serial_in));
  // Clock and hang guard
  always #25 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      tally_and_finish();
    end
  end
  // One AHB-Lite single transfer; waits on ready with no assumed latency
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_hsel <= 1; i_haddr <= {24'h0, a}; i_htrans <= 2'h2; i_hwrite <= w;
    do @(posedge i_ref_clk); while (o_hreadyout !== 1'b1);
    i_hsel <= 0; i_htrans <= 2'h0; i_hwdata <= d;
    do @(posedge i_ref_clk); while (o_hreadyout !== 1'b1);
    q = o_hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  // Expected pins from a control value, active low
  function automatic logic [31:0] pins(input logic [7:0] c);
    return {27'h0, ~c[6], ~c[3], ~c[2], ~c[1], ~c[0]};
  endfunction
  // Expected modem status: inverted levels, changes, ring trailing edge
  function automatic logic [31:0] mstat(input logic [3:0] o, input logic [3:0] n);
    return {24'h0, ~n, o[3] ^ n[3], ~o[2] & n[2], o[1] ^ n[1], o[0] ^ n[0]};
  endfunction
  // One-cycle strobe: buffer read when rd is set, else a finished character
  task automatic pulse(input logic rd);
    if (rd) i_rbr_read <= 1;
    else i_rx_done <= 1;
    tick(1);
    i_rbr_read <= 0;
    i_rx_done <= 0;
    tick(1);
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    void'($urandom(14171));
    tick(8);
    i_rstn <= 1;
    tick(3);
    chk({o_user_pin_three_n, o_user_pin_two_n, o_user_pin_one_n, o_send_request_n,
         o_terminal_ready_n}, 5'h1F);
    bus(0, UMS_OFS_CTRL, 0); chk(q, 0);
    bus(0, 8'h40, 0); chk(q, 0);
    repeat (6) begin
      v = 8'($urandom) & 8'hEF;
      bus(1, UMS_OFS_CTRL, {24'h0, v}); tick(3);
      chk({o_user_pin_three_n, o_user_pin_two_n, o_user_pin_one_n, o_send_request_n,
           o_terminal_ready_n}, pins(v));
      bus(0, UMS_OFS_CTRL, 0); chk(q, {24'h0, v & 8'h7F});
    end
    bus(0, UMS_OFS_MSTAT, 0); old_n = 4'hF;
    repeat (6) begin
      want_n <= 4'($urandom); tick(6);
      chk(o_modem_status_req, (mstat(old_n, want_n) & 32'hF) != 0);
      bus(0, UMS_OFS_MSTAT, 0); chk(q, mstat(old_n, want_n));
      old_n = want_n;
      bus(0, UMS_OFS_MSTAT, 0); chk(q, mstat(old_n, old_n));
    end
    bus(1, UMS_OFS_CTRL, 32'h15); tick(3);
    chk({o_loopback, o_serial_out, o_rx_serial, o_user_pin_one_n, o_terminal_ready_n},
        5'h1B);
    bus(0, UMS_OFS_MSTAT, 0); chk(q & 32'hF0, 32'h60);
    bus(1, UMS_OFS_LINE, 32'h07); tick(2);
    chk({o_fast_divider_toggle, o_inject_zero_stop, o_inject_wrong_parity}, 3'h7);
    i_rx_perr <= 1; pulse(0); i_rx_perr <= 0; pulse(0);
    chk({o_thr_empty_req, o_tx_dma_ready_n, o_rx_dma_ready_n}, 3'h4);
    bus(0, UMS_OFS_LINE, 0); chk(q, 32'hE5);
    bus(0, UMS_OFS_LINE, 0); chk(q, 32'hE1);
    // Summary bit stays up until a status read finds no flagged character left
    pulse(1); bus(0, UMS_OFS_LINE, 0); chk(q, 32'hE1);
    pulse(1); bus(0, UMS_OFS_LINE, 0); chk(q, 32'h60);
    // Without FIFOs a second character overruns the single holding slot
    i_fifo_en <= 0; pulse(0); chk(o_rx_store, 1);
    i_rx_perr <= 1; pulse(0); chk(o_rx_store, 0);
    i_rx_perr <= 0; bus(0, UMS_OFS_LINE, 0); chk(q, 32'h63);
    i_thr_write <= 1; bus(0, UMS_OFS_LINE, 0); chk(q, 32'h21);
    i_thr_write <= 0; pulse(1);
    // Second DMA mode follows the trigger levels, not the data counts
    i_fifo_en <= 1; i_rx_trigger_hit <= 1; i_txf_trigger_hit <= 1; i_txf_empty <= 0;
    bus(1, UMS_OFS_CTRL, 32'h20); tick(3);
    chk({o_thr_empty_req, o_tx_dma_ready_n, o_rx_dma_ready_n}, 3'h0);
    // Fast infrared: no loopback, no second DMA mode, only the infrared faults and the divider toggle
    i_fast_infrared_mode <= 1; bus(1, UMS_OFS_CTRL, 32'h31);
    bus(1, UMS_OFS_LINE, 32'h1F); tick(3);
    chk({o_loopback, o_terminal_ready_n, o_rx_dma_ready_n, o_inject_bad_crc,
         o_inject_bad_pulse_chips, o_fast_divider_toggle, o_inject_zero_stop,
         o_inject_wrong_parity}, 8'h3C);
    // Reset in mid-run returns the pins to idle and clears the control word
    i_rstn <= 0; tick(2); chk({o_hresp, o_terminal_ready_n}, 2'h1);
    i_rstn <= 1; tick(3); bus(0, UMS_OFS_CTRL, 0); chk(q, 0);
    tally_and_finish();
  end
endmodule // testbench
